//--- led_indicator_pkg.sv
package led_indicator_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  localparam int NUM_IND = 3;
  localparam int SRC_W = 4;

  // Register indices; the byte address is four times the index.
  localparam logic [ADDR_W-1:0] SRC_CFG_IDX = 12'h450;
  localparam logic [ADDR_W-1:0] OVR_CFG_IDX = 12'h451;
  localparam logic [ADDR_W-1:0] STATUS_IDX = 12'h458;
  localparam logic [ADDR_W-1:0] BASIC_STATUS_IDX = 12'h001;

  localparam logic [15:0] SRC_CFG_RESET = 16'h2610;
  localparam logic [15:0] OVR_CFG_RESET = 16'h0049;
  localparam logic [15:0] SRC_CFG_MASK = 16'h7fff;
  localparam logic [15:0] OVR_CFG_MASK = 16'he1ff;

  localparam int BYPASS_BIT = 14;
  localparam int RATE_LSB = 12;
  localparam int RATE_W = 2;
  localparam int OVR_STRIDE = 3;
  localparam int POL_OFS = 0;
  localparam int VAL_OFS = 1;
  localparam int EN_OFS = 2;

  localparam int CLK_HZ = 100_000_000;
  localparam int HALF_MS_20HZ = 50;
  localparam int HALF_MS_10HZ = 100;
  localparam int HALF_MS_5HZ = 200;
  localparam int HALF_MS_2HZ = 500;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int CYC_20HZ = HALF_MS_20HZ * CYC_PER_MS;
  localparam int CYC_10HZ = HALF_MS_10HZ * CYC_PER_MS;
  localparam int CYC_5HZ = HALF_MS_5HZ * CYC_PER_MS;
  localparam int CYC_2HZ = HALF_MS_2HZ * CYC_PER_MS;
  localparam int STRETCH_MS = 50;
  localparam int CYC_STRETCH = STRETCH_MS * CYC_PER_MS;
  localparam int CNT_W = 26;

  typedef enum logic [3:0] {
    SRC_LINK = 4'h0,
    SRC_LINK_ACT = 4'h1,
    SRC_LINK_TX = 4'h2,
    SRC_LINK_RX = 4'h3,
    SRC_MASTER = 4'h4,
    SRC_SLAVE = 4'h5,
    SRC_ACT = 4'h6,
    SRC_LOST = 4'h9,
    SRC_PRBS = 4'ha,
    SRC_XMII_ERR = 4'hb
  } src_sel_t;

endpackage

//--- led_channel.sv
`timescale 1ns/1ns
module led_channel
  import led_indicator_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [SRC_W-1:0] sel_in,
  input wire logic pol_in,
  input wire logic ovr_en_in,
  input wire logic ovr_val_in,
  input wire logic link_in,
  input wire logic master_in,
  input wire logic blink_in,
  input wire logic act_any_in,
  input wire logic act_tx_in,
  input wire logic act_rx_in,
  input wire logic act_str_in,
  input wire logic err_str_in,
  input wire logic lost_in,
  input wire logic lost_clr_in,
  input wire logic prbs_err_in,
  output logic pin_out,
  output logic state_out
);
  logic lost_q, lost_d;
  logic prbs_q, prbs_d;
  logic pin_q, pin_d;
  logic act;

  always_comb begin
    lost_d = lost_q;
    if (lost_clr_in) begin
      lost_d = 1'b0;
    end
    if (lost_in) begin
      lost_d = 1'b1;
    end
    prbs_d = prbs_q ^ prbs_err_in;
    unique case (sel_in)
      SRC_LINK: act = link_in;
      SRC_LINK_ACT: act = link_in & ~(act_any_in & blink_in);
      SRC_LINK_TX: act = link_in & ~(act_tx_in & blink_in);
      SRC_LINK_RX: act = link_in & ~(act_rx_in & blink_in);
      SRC_MASTER: act = link_in & master_in;
      SRC_SLAVE: act = link_in & ~master_in;
      SRC_ACT: act = act_str_in;
      SRC_LOST: act = lost_q;
      SRC_PRBS: act = prbs_q;
      SRC_XMII_ERR: act = err_str_in;
      default: act = 1'b0;
    endcase
    if (ovr_en_in) begin
      act = ovr_val_in;
    end
    pin_d = pol_in ? act : ~act;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      lost_q <= 1'b0;
      prbs_q <= 1'b0;
      pin_q <= 1'b0;
    end else begin
      lost_q <= lost_d;
      prbs_q <= prbs_d;
      pin_q <= pin_d;
    end
  end

  assign pin_out = pin_q;
  assign state_out = lost_q;

  property p_lost_hold;
    @(posedge clk_in) disable iff (rst_in)
      lost_q && !lost_clr_in |=> lost_q;
  endproperty
  a_lost_hold: assert property (p_lost_hold) else $error("lost dropped");

  property p_prbs_toggle;
    @(posedge clk_in) disable iff (rst_in)
      prbs_err_in |=> prbs_q != $past(prbs_q);
  endproperty
  a_prbs_toggle: assert property (p_prbs_toggle) else $error("no toggle");

  property p_override;
    @(posedge clk_in) disable iff (rst_in)
      ovr_en_in |=> pin_q == ($past(ovr_val_in) ~^ $past(pol_in));
  endproperty
  a_override: assert property (p_override) else $error("bad override");

  property p_reserved;
    @(posedge clk_in) disable iff (rst_in)
      !ovr_en_in && (sel_in == 4'h7 || sel_in == 4'h8 || sel_in >= 4'hc)
      |=> pin_q == !$past(pol_in);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved on");

  property p_master;
    @(posedge clk_in) disable iff (rst_in)
      !ovr_en_in && sel_in == SRC_MASTER && pol_in
      |=> pin_q == $past(link_in && master_in);
  endproperty
  a_master: assert property (p_master) else $error("bad master");

  property p_link;
    @(posedge clk_in) disable iff (rst_in)
      !ovr_en_in && sel_in == SRC_LINK && !pol_in
      |=> pin_q == !$past(link_in);
  endproperty
  a_link: assert property (p_link) else $error("bad link");

endmodule

//--- led_indicator_control.sv
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ns
// What this block does
// - A two-bit rate field picks blink halves of 50, 100, 200 or 500 ms.
// - The bypass bit drives activity and errors without stretching.
// - Code 0 shows link up; code 1 adds blinking on any activity.
// - Code 2 blinks on transmit only; code 3 blinks on receive only.
// - Codes 4 and 5 show link up as master or as slave.
// - Code 6 shows combined activity, stretched unless bypassed.
// - Code 9 latches on link loss until the basic status is read.
// - Code 10 toggles the indicator on each PRBS checker error.
// - Code 11 shows xMII errors, stretched unless bypassed.
// - Selectors for outputs 1 and 2 sit at bits 7-4 and 11-8.
// - An override enable drives the override value instead.
// - Polarity 0 makes an output active low and 1 active high.
// - The third output drives only when the clock pin carries it.
module led_indicator_control
  import led_indicator_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [led_indicator_pkg::ADDR_W+1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic link_up_in,
  input wire logic master_in,
  input wire logic tx_act_in,
  input wire logic rx_act_in,
  input wire logic link_lost_in,
  input wire logic prbs_err_in,
  input wire logic xmii_err_in,
  input wire logic clkout_is_ind_in,
  output logic [led_indicator_pkg::NUM_IND-1:0] ind_out,
  output logic [led_indicator_pkg::NUM_IND-1:0] ind_oe_out
);
  import led_indicator_pkg::*;

  logic [15:0] src_q, src_d;
  logic [15:0] ovr_q, ovr_d;
  logic [31:0] rdata_q, rdata_d;
  logic ack_q, ack_d;
  logic [2:0] pin_sync_q, pin_sync_d;
  logic pin_sel_q, pin_sel_d;
  logic [CNT_W-1:0] blink_cnt_q, blink_cnt_d;
  logic blink_q, blink_d;
  logic [CNT_W-1:0] act_cnt_q, act_cnt_d;
  logic [CNT_W-1:0] err_cnt_q, err_cnt_d;
  logic [NUM_IND-1:0] pins;
  logic [NUM_IND-1:0] lost_st;
  logic [ADDR_W-1:0] idx;
  logic req, lost_clr, act_any, act_str, err_str;
  logic [CNT_W-1:0] half_cyc;

  assign idx = avs_address_in[ADDR_W+1:2];
  assign req = (avs_read_in | avs_write_in) & ~ack_q;
  assign avs_waitrequest_out = req;
  assign avs_readdata_out = rdata_q;
  assign lost_clr = ack_q & avs_read_in & (idx == BASIC_STATUS_IDX);
  assign act_any = tx_act_in | rx_act_in;

  always_comb begin
    unique case (src_q[RATE_LSB+:RATE_W])
      2'h0: half_cyc = CNT_W'(CYC_20HZ);
      2'h1: half_cyc = CNT_W'(CYC_10HZ);
      2'h2: half_cyc = CNT_W'(CYC_5HZ);
      2'h3: half_cyc = CNT_W'(CYC_2HZ);
    endcase
  end

  always_comb begin
    src_d = src_q;
    ovr_d = ovr_q;
    rdata_d = rdata_q;
    ack_d = req;
    if (ack_q && avs_write_in && avs_byteenable_in[1:0] == 2'h3) begin
      if (idx == SRC_CFG_IDX) begin
        src_d = avs_writedata_in[15:0] & SRC_CFG_MASK;
      end
      if (idx == OVR_CFG_IDX) begin
        ovr_d = avs_writedata_in[15:0] & OVR_CFG_MASK;
      end
    end
    if (req && avs_read_in) begin
      unique case (idx)
        SRC_CFG_IDX: rdata_d = {16'h0000, src_q};
        OVR_CFG_IDX: rdata_d = {16'h0000, ovr_q};
        STATUS_IDX: rdata_d = {25'h0000000, pin_sel_q, blink_q, lost_st,
                               pins[1:0]};
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  always_comb begin
    pin_sync_d = {pin_sync_q[1:0], clkout_is_ind_in};
    pin_sel_d = pin_sel_q;
    if (pin_sync_q[2] == pin_sync_q[1]) begin
      pin_sel_d = pin_sync_q[2];
    end
    blink_cnt_d = blink_cnt_q + 1'b1;
    blink_d = blink_q;
    if (blink_cnt_q >= half_cyc - 1'b1) begin
      blink_cnt_d = '0;
      blink_d = ~blink_q;
    end
    act_cnt_d = (act_cnt_q != '0) ? act_cnt_q - 1'b1 : act_cnt_q;
    if (act_any) begin
      act_cnt_d = CNT_W'(CYC_STRETCH);
    end
    err_cnt_d = (err_cnt_q != '0) ? err_cnt_q - 1'b1 : err_cnt_q;
    if (xmii_err_in) begin
      err_cnt_d = CNT_W'(CYC_STRETCH);
    end
    if (src_q[BYPASS_BIT]) begin
      act_str = act_any;
      err_str = xmii_err_in;
    end else begin
      act_str = act_any | (act_cnt_q != '0);
      err_str = xmii_err_in | (err_cnt_q != '0);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      src_q <= SRC_CFG_RESET;
      ovr_q <= OVR_CFG_RESET;
      rdata_q <= 32'h00000000;
      ack_q <= 1'b0;
      pin_sync_q <= 3'h0;
      pin_sel_q <= 1'b0;
      blink_cnt_q <= '0;
      blink_q <= 1'b0;
      act_cnt_q <= '0;
      err_cnt_q <= '0;
    end else begin
      src_q <= src_d;
      ovr_q <= ovr_d;
      rdata_q <= rdata_d;
      ack_q <= ack_d;
      pin_sync_q <= pin_sync_d;
      pin_sel_q <= pin_sel_d;
      blink_cnt_q <= blink_cnt_d;
      blink_q <= blink_d;
      act_cnt_q <= act_cnt_d;
      err_cnt_q <= err_cnt_d;
    end
  end

  for (genvar i = 0; i < NUM_IND; i++) begin : g_ch
    led_channel u_ch (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .sel_in(src_q[i*SRC_W+:SRC_W]),
      .pol_in(ovr_q[i*OVR_STRIDE+POL_OFS]),
      .ovr_en_in(ovr_q[i*OVR_STRIDE+EN_OFS]),
      .ovr_val_in(ovr_q[i*OVR_STRIDE+VAL_OFS]),
      .link_in(link_up_in),
      .master_in(master_in),
      .blink_in(blink_q),
      .act_any_in(act_any),
      .act_tx_in(tx_act_in),
      .act_rx_in(rx_act_in),
      .act_str_in(act_str),
      .err_str_in(err_str),
      .lost_in(link_lost_in),
      .lost_clr_in(lost_clr),
      .prbs_err_in(prbs_err_in),
      .pin_out(pins[i]),
      .state_out(lost_st[i])
    );
  end

  assign ind_out = {pins[2] & pin_sel_q, pins[1:0]};
  assign ind_oe_out = {pin_sel_q, 2'h3};

  property p_bus_one_wait;
    @(posedge clk_in) disable iff (rst_in)
      (avs_read_in || avs_write_in) && avs_waitrequest_out
      |=> !avs_waitrequest_out;
  endproperty
  a_bus_one_wait: assert property (p_bus_one_wait) else $error("wait");

  property p_write_src;
    @(posedge clk_in) disable iff (rst_in)
      ack_q && avs_write_in && idx == SRC_CFG_IDX &&
      avs_byteenable_in[1:0] == 2'h3
      |=> src_q == ($past(avs_writedata_in[15:0]) & SRC_CFG_MASK);
  endproperty
  a_write_src: assert property (p_write_src) else $error("src write");

  property p_blink_period;
    @(posedge clk_in) disable iff (rst_in)
      blink_cnt_q != '0 && blink_cnt_q < half_cyc - 1'b1 && $stable(half_cyc)
      |=> $stable(blink_q);
  endproperty
  a_blink_period: assert property (p_blink_period) else $error("blink");

  property p_bypass;
    @(posedge clk_in) disable iff (rst_in)
      src_q[BYPASS_BIT] |-> act_str == act_any && err_str == xmii_err_in;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass");

  property p_stretch;
    @(posedge clk_in) disable iff (rst_in)
      !src_q[BYPASS_BIT] && act_any ##1 !src_q[BYPASS_BIT] |-> act_str;
  endproperty
  a_stretch: assert property (p_stretch) else $error("stretch");

  property p_pin2;
    @(posedge clk_in) disable iff (rst_in)
      !pin_sel_q |-> !ind_oe_out[2] && !ind_out[2];
  endproperty
  a_pin2: assert property (p_pin2) else $error("third pin");

  property p_no_early_write;
    @(posedge clk_in) disable iff (rst_in)
      req |=> src_q == $past(src_q) && ovr_q == $past(ovr_q);
  endproperty
  a_no_early_write: assert property (p_no_early_write) else $error("early");

  property p_write_ovr;
    @(posedge clk_in) disable iff (rst_in)
      ack_q && avs_write_in && idx == OVR_CFG_IDX &&
      avs_byteenable_in[1:0] == 2'h3
      |=> ovr_q == ($past(avs_writedata_in[15:0]) & OVR_CFG_MASK);
  endproperty
  a_write_ovr: assert property (p_write_ovr) else $error("ovr write");

  property p_write_refused;
    @(posedge clk_in) disable iff (rst_in)
      ack_q && avs_write_in && avs_byteenable_in[1:0] != 2'h3
      |=> $stable(src_q) && $stable(ovr_q);
  endproperty
  a_write_refused: assert property (p_write_refused) else $error("refused");

  property p_read_src;
    @(posedge clk_in) disable iff (rst_in)
      req && avs_read_in && idx == SRC_CFG_IDX
      |=> avs_readdata_out == {16'h0000, $past(src_q)};
  endproperty
  a_read_src: assert property (p_read_src) else $error("src read");

  property p_read_unmapped;
    @(posedge clk_in) disable iff (rst_in)
      req && avs_read_in && idx != SRC_CFG_IDX && idx != OVR_CFG_IDX &&
      idx != STATUS_IDX |=> avs_readdata_out == 32'h00000000;
  endproperty
  a_read_unmapped: assert property (p_read_unmapped) else $error("unmapped");

  property p_wait_first;
    @(posedge clk_in) disable iff (rst_in)
      (avs_read_in || avs_write_in) && !ack_q |-> avs_waitrequest_out;
  endproperty
  a_wait_first: assert property (p_wait_first) else $error("no wait");

  property p_blink_wrap;
    @(posedge clk_in) disable iff (rst_in)
      blink_cnt_q >= half_cyc - 1'b1 |=> blink_q != $past(blink_q);
  endproperty
  a_blink_wrap: assert property (p_blink_wrap) else $error("wrap");

  property p_stretch_err;
    @(posedge clk_in) disable iff (rst_in)
      !src_q[BYPASS_BIT] && xmii_err_in ##1 !src_q[BYPASS_BIT] |-> err_str;
  endproperty
  a_stretch_err: assert property (p_stretch_err) else $error("err");

  property p_sel_follow;
    @(posedge clk_in) disable iff (rst_in)
      pin_sync_q[2] == pin_sync_q[1] |=> pin_sel_q == $past(pin_sync_q[2]);
  endproperty
  a_sel_follow: assert property (p_sel_follow) else $error("sel");

  property p_sel_hold;
    @(posedge clk_in) disable iff (rst_in)
      pin_sync_q[2] != pin_sync_q[1] |=> $stable(pin_sel_q);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("sel hold");

  property p_lost_clear;
    @(posedge clk_in) disable iff (rst_in)
      lost_clr && !link_lost_in |=> lost_st == '0;
  endproperty
  a_lost_clear: assert property (p_lost_clear) else $error("clear");

endmodule

//--- led_lamps.sv
`timescale 1ns/1ns
module led_lamps (
  input wire logic [2:0] ind_in,
  input wire logic [2:0] oe_in,
  output logic [2:0] lit_out
);
  // A lamp glows only while its pin is driven high; a released pin is dark.
  assign lit_out = ind_in & oe_in;
endmodule

//--- led_indicator_control_tb.sv
`timescale 1ns/1ns
module led_indicator_control_tb;
  import led_indicator_pkg::*;
  logic clk_in, rst_in, rd, wr, wait_o, snap;
  logic link, mst, tx, rx, lost, prbs, xerr, clko;
  logic [13:0] addr;
  logic [31:0] wdata, rdata, seed;
  logic [3:0] be;
  logic [2:0] ind, oe, lit;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  int n_errors, checked;
  // Source word, override word, {link,master,tx,rx,xmii}, {oe,pins}.
  localparam logic [42:0] TBL [11] = '{
    {16'h4540, 16'h0049, 5'h18, 6'h3b}, {16'h4540, 16'h0049, 5'h10, 6'h3d},
    {16'h4540, 16'h0049, 5'h00, 6'h38}, {16'h4321, 16'h0049, 5'h10, 6'h3f},
    {16'h4b76, 16'h0049, 5'h15, 6'h3d}, {16'h4b76, 16'h0049, 5'h10, 6'h38},
    {16'h4540, 16'h0000, 5'h18, 6'h3c}, {16'h4540, 16'h01ef, 5'h00, 6'h3d},
    {16'h4fc8, 16'h0000, 5'h10, 6'h3f}, {16'h0006, 16'h0049, 5'h04, 6'h39},
    {16'h0006, 16'h0049, 5'h00, 6'h39}};

  led_indicator_control dut (.clk_in(clk_in), .rst_in(rst_in),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdata), .avs_byteenable_in(be),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wait_o),
    .link_up_in(link), .master_in(mst), .tx_act_in(tx), .rx_act_in(rx),
    .link_lost_in(lost), .prbs_err_in(prbs), .xmii_err_in(xerr),
    .clkout_is_ind_in(clko), .ind_out(ind), .ind_oe_out(oe));
  led_lamps lamps (.ind_in(ind), .oe_in(oe), .lit_out(lit));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Results are compared in mid-cycle, where they are settled.
  always @(negedge clk_in) begin
    if ((rd && wait_o === 1'b0) || snap) begin
      e = exp_q.pop_front();
      if (snap) begin
        chk("pins", {26'h0, oe, ind}, e[31:0]);
        chk("lamps", {29'h0, lit}, {29'h0, e[5:3] & e[2:0]});
      end else if (!e[32]) begin
        chk("readdata", rdata, e[31:0]);
      end
    end
  end

  task automatic bus(input logic r, input logic [13:0] a,
                     input logic [31:0] d, input logic [3:0] b);
    @(posedge clk_in);
    rd <= r;
    wr <= !r;
    addr <= a;
    wdata <= d;
    be <= b;
    @(negedge clk_in);
    while (wait_o !== 1'b0) begin
      @(negedge clk_in);
    end
    @(posedge clk_in);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rdreg(input logic [13:0] a, input logic [32:0] x);
    exp_q.push_back(x);
    bus(1'b1, a, 32'h0, 4'hf);
  endtask

  task automatic setp(input logic [15:0] s, o);
    bus(1'b0, 14'h1140, {16'h0, s}, 4'hf);
    bus(1'b0, 14'h1144, {16'h0, o}, 4'hf);
  endtask

  task automatic peek(input logic [4:0] i, input logic [5:0] x);
    @(posedge clk_in);
    {link, mst, tx, rx, xerr} <= i;
    repeat (4) @(posedge clk_in);
    exp_q.push_back({27'h0, x});
    snap <= 1'b1;
    @(posedge clk_in);
    snap <= 1'b0;
  endtask

  task automatic pulse(input bit p);
    @(posedge clk_in);
    if (p) prbs <= 1'b1;
    else lost <= 1'b1;
    @(posedge clk_in);
    prbs <= 1'b0;
    lost <= 1'b0;
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    #1000000;
    n_errors++;
    test_done();
  end

  initial begin
    logic [31:0] w;
    seed = 32'd69488;
    {rd, wr, snap, link, mst, tx, rx, lost, prbs, xerr} = 10'h0;
    addr = 14'h0;
    wdata = 32'h0;
    be = 4'h0;
    clko = 1'b1;
    rst_in = 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    rdreg(14'h1140, {17'h0, SRC_CFG_RESET});
    rdreg(14'h1144, {17'h0, OVR_CFG_RESET});
    rdreg(14'h0008, 33'h0);
    w = rnd();
    bus(1'b0, 14'h1140, w, 4'hf);
    rdreg(14'h1140, {17'h0, w[15:0] & SRC_CFG_MASK});
    bus(1'b0, 14'h1140, rnd(), 4'hc);
    rdreg(14'h1140, {17'h0, w[15:0] & SRC_CFG_MASK});
    bus(1'b0, 14'h1144, 32'hffff, 4'hf);
    rdreg(14'h1144, {17'h0, OVR_CFG_MASK});
    $display("test registers done");
    for (int k = 0; k < 11; k++) begin
      setp(TBL[k][42:27], TBL[k][26:11]);
      peek(TBL[k][10:6], TBL[k][5:0]);
    end
    $display("test sources done");
    setp(16'h4009, 16'h0049);
    pulse(1'b0);
    peek(5'h00, 6'h39);
    rdreg(14'h0004, 33'h100000000);
    peek(5'h00, 6'h38);
    setp(16'h400a, 16'h0049);
    pulse(1'b1);
    peek(5'h00, 6'h39);
    pulse(1'b1);
    peek(5'h00, 6'h38);
    $display("test latches done");
    @(posedge clk_in);
    clko <= 1'b0;
    setp(16'h4000, 16'h0049);
    peek(5'h10, 6'h1b);
    $display("test third output done");
    test_done();
  end
endmodule
